// ---- rtl/lnbi_i2c_port.sv ----
// two-wire slave register port of the dual lnb supply controller

// What this block does
// (RULE_01) idle lines high; only release or pull low
// (RULE_02) accept up to 400 kbps, one clock per bit
// (RULE_03) sda changes only while scl low
// (RULE_04) sda fall/rise with scl high: start/stop
// (RULE_05) master stops before every new start
// (RULE_06) bytes are eight bits, msb first, plus acknowledge
// (RULE_07) addressed device pulls sda low on ninth clock
// (RULE_08) no acknowledge while power-good is low
// (RULE_09) address pattern match; lsb one means read
// (RULE_10) start, address, one data byte, stop
// (RULE_11) direction zero writes any of eight registers
// (RULE_12) all eight registers clear at power-on
// (RULE_13) channel one status: select, five fault flags
// (RULE_14) channel two status: select, spare, four flags
// (RULE_15) tone registers: three writable bits, two spare
// (RULE_16) command registers: five writable limit bits
// (RULE_17) control registers: power, spares, two range bits
// (RULE_18) overload flag follows current limiting state
// (RULE_19) reverse current flag follows back-current limiting
// (RULE_20) cable open flag follows open-cable detection
// (RULE_21) overheat flag follows thermal shutdown
// (RULE_22) writes never change read-only flag bits
// (RULE_23) reads return last selected register
module lnbi_i2c_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addrStrap,
    input wire logic undervoltageLockoutOk,
    input wire logic overheatFlag,
    input wire lnbi_pkg::lnbi_chan_flags_s ch1Flags,
    input wire lnbi_pkg::lnbi_chan_flags_s ch2Flags,
    output lnbi_pkg::lnbi_chan_ctrl_s [1:0] chanCtrl
);

    // asynchronous inputs gathered for the two-flop synchroniser
    localparam int SYNC_W = 13;
    logic [SYNC_W-1:0] asyncIn;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;

    // synchronised views
    logic sclS;
    logic sdaS;
    logic strapS;
    logic pwrS;
    logic overheatS;
    lnbi_pkg::lnbi_chan_flags_s flags1S;
    lnbi_pkg::lnbi_chan_flags_s flags2S;

    // frame detection
    logic sdaPrev_q;
    logic startSeen;
    logic stopSeen;
    logic inFrame_q;
    logic linkRst_n;

    // register file and readback
    logic [2:0] sel_q;
    lnbi_pkg::lnbi_chan_ctrl_s [1:0] chanCtrl_q;
    logic [7:0] readValue;
    logic [7:0] snapData_q;
    logic snapPwr_q;
    logic snapStrap_q;

    // write handshake from the link domain
    logic [7:0] wrData_q;
    logic wrToggle_q;
    logic wrTogMeta_q;
    logic wrTogSync_q;
    logic wrTogPrev_q;
    logic wrEvent;

    // link domain state
    logic [3:0] bitCnt_q;
    logic [6:0] shift_q;
    lnbi_pkg::lnbi_phase_e phase_q;
    logic addrHit_q;
    logic readDir_q;
    logic masterNack_q;
    logic sdaOe_q;
    logic sdaOut_q;
    logic [7:0] fullByte;
    logic [3:0] bitDiff;
    logic respond;

    // pins and flags into one vector
    assign asyncIn = {sclIn, sdaIn, addrStrap, undervoltageLockoutOk, overheatFlag,
                      ch1Flags, ch2Flags};

    // two flops before any clk-domain logic looks at an outside level, plus the write toggle
    // bus lines reset to idle high so no false start or stop follows reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= {lnbi_pkg::BUS_IDLE, 11'h000};
            sync_q <= {lnbi_pkg::BUS_IDLE, 11'h000};
            sdaPrev_q <= 1'b1;
            wrTogMeta_q <= 1'b0;
            wrTogSync_q <= 1'b0;
            wrTogPrev_q <= 1'b0;
        end
        else
        begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
            sdaPrev_q <= sdaS;
            wrTogMeta_q <= wrToggle_q;
            wrTogSync_q <= wrTogMeta_q;
            wrTogPrev_q <= wrTogSync_q;
        end
    end

    // unpack the synchronised vector
    assign {sclS, sdaS, strapS, pwrS, overheatS, flags1S, flags2S} = sync_q;

    // start and stop are sda edges while scl is high
    assign startSeen = sclS & sdaPrev_q & ~sdaS; // RULE_04
    assign stopSeen = sclS & ~sdaPrev_q & sdaS; // RULE_04

    // frame flag; a repeated start is not expected, so a start only opens
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            inFrame_q <= 1'b0;
        end
        else if (stopSeen)
        begin
            inFrame_q <= 1'b0; // RULE_04
        end
        else if (startSeen)
        begin
            inFrame_q <= 1'b1; // RULE_04 RULE_05
        end
    end

    // link logic is held clear outside a frame, released after the start
    assign linkRst_n = rst_n & inFrame_q;

    // one cycle per written byte; wrData_q is stable long before
    assign wrEvent = wrTogSync_q ^ wrTogPrev_q;

    // selection of the register for later reads
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_q <= lnbi_pkg::SEL_RESET; // RULE_12
        end
        else if (wrEvent)
        begin
            sel_q <= wrData_q[lnbi_pkg::SEL_MSB:lnbi_pkg::SEL_LSB]; // RULE_11 RULE_23
        end
    end

    // per-channel writable registers
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            // write the fields of the kind that the select field names
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    chanCtrl_q[ch] <= lnbi_pkg::CTRL_RESET; // RULE_12
                end
                else if (wrEvent && (wrData_q[lnbi_pkg::SEL_MSB] == 1'(ch)))
                begin
                    unique case (wrData_q[lnbi_pkg::SEL_MSB-1:lnbi_pkg::SEL_LSB])
                        // status: flags are read-only, only selection takes effect
                        lnbi_pkg::KIND_STATUS:
                        begin
                            chanCtrl_q[ch] <= chanCtrl_q[ch]; // RULE_22
                        end
                        // tone: three bits, two spare
                        lnbi_pkg::KIND_TONE:
                        begin
                            chanCtrl_q[ch].toneContinuousOn <=
                                wrData_q[lnbi_pkg::TONE_CONT_POS]; // RULE_15
                            chanCtrl_q[ch].extModSelect <= wrData_q[lnbi_pkg::TONE_EXTMOD_POS];
                            chanCtrl_q[ch].detectThresholdSel <=
                                wrData_q[lnbi_pkg::TONE_THRESH_POS];
                        end
                        // command: limit mode, pin select and threshold
                        lnbi_pkg::KIND_COMMAND:
                        begin
                            chanCtrl_q[ch].staticLimitSel <=
                                wrData_q[lnbi_pkg::CMD_STATIC_POS]; // RULE_16
                            chanCtrl_q[ch].pinVoltSelectEn <= wrData_q[lnbi_pkg::CMD_PINSEL_POS];
                            chanCtrl_q[ch].limitRangeBit <= wrData_q[lnbi_pkg::CMD_RANGE_POS];
                            chanCtrl_q[ch].limitHighBit <= wrData_q[lnbi_pkg::CMD_HIGH_POS];
                            chanCtrl_q[ch].limitLowBit <= wrData_q[lnbi_pkg::CMD_LOW_POS];
                        end
                        // control: power and range bits, two spare
                        lnbi_pkg::KIND_CONTROL:
                        begin
                            chanCtrl_q[ch].powerOn <= wrData_q[lnbi_pkg::CTL_POWER_POS]; // RULE_17
                            chanCtrl_q[ch].highRangeSel <= wrData_q[lnbi_pkg::CTL_HIGH_POS];
                            chanCtrl_q[ch].lowRangeSel <= wrData_q[lnbi_pkg::CTL_LOW_POS];
                        end
                    endcase
                end
            end
        end
    endgenerate

    // control outputs straight from the register flops
    assign chanCtrl = chanCtrl_q;

    // readback byte of the selected register
    always_comb
    begin
        readValue = {sel_q, 5'h00};
        unique case (sel_q[1:0])
            // live fault flags; channel two has a spare bit on top
            lnbi_pkg::KIND_STATUS:
            begin
                readValue[4:0] = sel_q[2] ? {1'b0, flags2S} // RULE_14 RULE_19 RULE_20
                                          : {overheatS, flags1S}; // RULE_13 RULE_18 RULE_21
            end
            // tone bits, spares read zero
            lnbi_pkg::KIND_TONE:
            begin
                readValue[4:0] = {chanCtrl_q[sel_q[2]].toneContinuousOn,
                                  chanCtrl_q[sel_q[2]].extModSelect,
                                  chanCtrl_q[sel_q[2]].detectThresholdSel, 2'b00}; // RULE_15
            end
            // command bits
            lnbi_pkg::KIND_COMMAND:
            begin
                readValue[4:0] = {chanCtrl_q[sel_q[2]].staticLimitSel,
                                  chanCtrl_q[sel_q[2]].pinVoltSelectEn,
                                  chanCtrl_q[sel_q[2]].limitRangeBit,
                                  chanCtrl_q[sel_q[2]].limitHighBit,
                                  chanCtrl_q[sel_q[2]].limitLowBit}; // RULE_16
            end
            // control bits, spares read zero
            lnbi_pkg::KIND_CONTROL:
            begin
                readValue[4:0] = {chanCtrl_q[sel_q[2]].powerOn, 2'b00,
                                  chanCtrl_q[sel_q[2]].highRangeSel,
                                  chanCtrl_q[sel_q[2]].lowRangeSel}; // RULE_17
            end
        endcase
    end

    // snapshot frozen for the whole frame; the link reads it without further sync
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            snapData_q <= '0;
            snapPwr_q <= 1'b0;
            snapStrap_q <= 1'b0;
        end
        else if (!inFrame_q)
        begin
            snapData_q <= readValue; // RULE_23
            snapPwr_q <= pwrS;
            snapStrap_q <= strapS;
        end
    end

    // incoming byte including the bit on this edge
    assign fullByte = {shift_q, sdaIn};

    // receive side: bits taken on scl rising, msb first
    always_ff @(posedge sclClk or negedge linkRst_n)
    begin
        if (!linkRst_n)
        begin
            bitCnt_q <= '0;
            shift_q <= '0;
            phase_q <= lnbi_pkg::PH_ADDR;
            addrHit_q <= 1'b0;
            readDir_q <= 1'b0;
            masterNack_q <= 1'b0;
        end
        else if (bitCnt_q == lnbi_pkg::ACK_BIT)
        begin
            // ninth clock closes the byte; a master nack ends a read
            bitCnt_q <= '0; // RULE_06
            phase_q <= lnbi_pkg::PH_DATA; // RULE_10
            masterNack_q <= (phase_q == lnbi_pkg::PH_DATA) && readDir_q && sdaIn;
        end
        else
        begin
            shift_q <= fullByte[6:0]; // RULE_02 RULE_06
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q == lnbi_pkg::LAST_DATA_BIT && phase_q == lnbi_pkg::PH_ADDR)
            begin
                addrHit_q <= (fullByte[7:2] == lnbi_pkg::DEV_ADDR_HI)
                             && (fullByte[1] == snapStrap_q); // RULE_09
                readDir_q <= (fullByte[0] == lnbi_pkg::DIR_READ); // RULE_09
            end
        end
    end

    // written byte and its toggle outlive the frame, so only rst_n clears them
    always_ff @(posedge sclClk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrData_q <= '0;
            wrToggle_q <= 1'b0;
        end
        else if (inFrame_q && bitCnt_q == lnbi_pkg::LAST_DATA_BIT
                 && phase_q == lnbi_pkg::PH_DATA && addrHit_q && !readDir_q && snapPwr_q)
        begin
            wrData_q <= fullByte; // RULE_11
            wrToggle_q <= ~wrToggle_q;
        end
    end

    // device answers only when addressed and power is good
    assign respond = addrHit_q & snapPwr_q; // RULE_08
    // bit of the read byte for the current slot
    assign bitDiff = lnbi_pkg::LAST_DATA_BIT - bitCnt_q;

    // transmit side: sda changes on scl falling only
    always_ff @(negedge sclClk or negedge linkRst_n)
    begin
        if (!linkRst_n)
        begin
            sdaOe_q <= 1'b0; // RULE_01
            sdaOut_q <= 1'b0;
        end
        else
        begin
            sdaOut_q <= 1'b0; // RULE_01
            sdaOe_q <= 1'b0;
            if (bitCnt_q == lnbi_pkg::ACK_BIT)
            begin
                // acknowledge the address, or a written byte
                sdaOe_q <= respond && (phase_q == lnbi_pkg::PH_ADDR || !readDir_q); // RULE_07
            end
            else if (phase_q == lnbi_pkg::PH_DATA && respond && readDir_q && !masterNack_q)
            begin
                sdaOe_q <= ~snapData_q[bitDiff[2:0]]; // RULE_03 RULE_23
            end
        end
    end

    // open-drain pin: output low, enable pulls
    assign sdaOe = sdaOe_q;
    assign sdaOut = sdaOut_q;

    // checks on the frame and register side
    a_start_opens_frame: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        (startSeen && !stopSeen) |=> inFrame_q)
        else $error("start did not open a frame");
    a_stop_closes_frame: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        stopSeen |=> !inFrame_q)
        else $error("stop did not close the frame");
    a_write_selects_reg: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        wrEvent |=> sel_q == $past(wrData_q[7:5]))
        else $error("write did not update the selection");
    a_status_write_ro: assert property (@(posedge clk) disable iff (!rst_n) // RULE_22
        (wrEvent && wrData_q[6:5] == lnbi_pkg::KIND_STATUS) |=> $stable(chanCtrl_q))
        else $error("status write changed control bits");
    a_snap_frozen: assert property (@(posedge clk) disable iff (!rst_n) // RULE_23
        (inFrame_q && $past(inFrame_q)) |-> $stable(snapData_q))
        else $error("readback changed inside a frame");
    a_readback_sel: assert property (@(posedge clk) disable iff (!rst_n) // RULE_23
        !inFrame_q |=> snapData_q[7:5] == $past(sel_q))
        else $error("readback select bits wrong");
    a_overload_read: assert property (@(posedge clk) disable iff (!rst_n) // RULE_18
        (!inFrame_q && sel_q == 3'h0) |=> snapData_q[1] == $past(flags1S.overloadFlag))
        else $error("overload flag not reported");
    a_power_off_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
        (inFrame_q && !snapPwr_q) |-> !sdaOe_q)
        else $error("pulled sda without power good");

    // checks on the link side
    a_byte_nine_clocks: assert property (@(posedge sclClk) disable iff (!linkRst_n) // RULE_06
        bitCnt_q <= lnbi_pkg::ACK_BIT)
        else $error("bit counter beyond acknowledge slot");
    a_addr_ack_held: assert property (@(posedge sclClk) disable iff (!linkRst_n) // RULE_07
        (bitCnt_q == lnbi_pkg::ACK_BIT && phase_q == lnbi_pkg::PH_ADDR && respond) |-> sdaOe_q)
        else $error("addressed device did not acknowledge");

    // main scenarios
    c_frame_start: cover property (@(posedge clk) disable iff (!rst_n) startSeen);
    c_reg_write: cover property (@(posedge clk) disable iff (!rst_n) wrEvent);
    c_read_bit: cover property (@(negedge sclClk) disable iff (!linkRst_n)
        readDir_q && phase_q == lnbi_pkg::PH_DATA && sdaOe_q);

endmodule

// ---- rtl/lnbi_pkg.sv ----
// shared constants and carrier types of the dual lnb supply serial register port
package lnbi_pkg;

    // upper six bits of the bus address byte; bit 1 follows the strap, bit 0 is direction
    localparam logic [5:0] DEV_ADDR_HI = 6'h04;
    // direction bit value that asks the device to send
    localparam logic DIR_READ = 1'b1;
    // scl and sda levels of a free bus, reset value of their synchronisers
    localparam logic [1:0] BUS_IDLE = 2'h3;

    // bit counter values inside one nine-clock byte slot
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;

    // select field position in every data byte
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 5;
    // select field: bit 2 picks the channel, bits 1:0 the register kind
    localparam logic [1:0] KIND_STATUS = 2'h0;
    localparam logic [1:0] KIND_TONE = 2'h1;
    localparam logic [1:0] KIND_COMMAND = 2'h2;
    localparam logic [1:0] KIND_CONTROL = 2'h3;
    localparam logic [2:0] SEL_RESET = 3'h0;

    // field positions below the select field
    localparam int TONE_CONT_POS = 4;
    localparam int TONE_EXTMOD_POS = 3;
    localparam int TONE_THRESH_POS = 2;
    localparam int CMD_STATIC_POS = 4;
    localparam int CMD_PINSEL_POS = 3;
    localparam int CMD_RANGE_POS = 2;
    localparam int CMD_HIGH_POS = 1;
    localparam int CMD_LOW_POS = 0;
    localparam int CTL_POWER_POS = 4;
    localparam int CTL_HIGH_POS = 1;
    localparam int CTL_LOW_POS = 0;

    // per-channel writable control bits
    typedef struct packed {
        logic powerOn;
        logic highRangeSel;
        logic lowRangeSel;
        logic staticLimitSel;
        logic pinVoltSelectEn;
        logic limitRangeBit;
        logic limitHighBit;
        logic limitLowBit;
        logic toneContinuousOn;
        logic extModSelect;
        logic detectThresholdSel;
    } lnbi_chan_ctrl_s;

    // per-channel read-only fault flags, in register bit order 3..0
    typedef struct packed {
        logic cableOpenFlag;
        logic voltRangeFlag;
        logic overloadFlag;
        logic reverseCurrentFlag;
    } lnbi_chan_flags_s;

    // every control bit clears at power-on
    localparam lnbi_chan_ctrl_s CTRL_RESET = '0;

    // byte phase of the link, one-hot
    typedef enum logic [1:0] {
        PH_ADDR = 2'b01,
        PH_DATA = 2'b10
    } lnbi_phase_e;

endpackage

// ---- testbench/lnbi_host_model.sv ----
// host bus master model driving the two-wire register port
module lnbi_host_model (
    output logic scl,
    output logic sdaLow,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // quarter of the 125 ns bus clock period
    localparam real Q = 31.25;

    // bus idles with both lines released, clock stands still between frames
    initial
    begin
        scl = 1'h1;
        sdaLow = 1'h0;
    end

    // one bit slot: data set while clock low, sampled mid high phase
    task automatic bitSlot(input logic b, output logic seen);
    begin
        #(Q) sdaLow = !b;
        #(Q) scl = 1'h1;
        #(Q) seen = sda;
        #(Q) scl = 1'h0;
    end
    endtask

    // data falls while clock high
    task automatic startCond();
    begin
        #(Q) sdaLow = 1'h1;
        #(2*Q) scl = 1'h0;
    end
    endtask

    // data rises while clock high, then bus free
    task automatic stopCond();
    begin
        #(Q) sdaLow = 1'h1;
        #(Q) scl = 1'h1;
        #(2*Q) sdaLow = 1'h0;
        #(4*Q);
    end
    endtask

    // eight bits msb first, then release for the acknowledge
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic s;
    begin
        for (int i = 7; i >= 0; i--)
            bitSlot(d[i], s);
        bitSlot(1'h1, s);
        ack = !s;
    end
    endtask

    // eight bits from the device, then our acknowledge or not
    task automatic recvByte(input logic ackIt, output logic [7:0] d);
        logic s;
    begin
        for (int i = 7; i >= 0; i--)
            bitSlot(1'h1, d[i]);
        bitSlot(!ackIt, s);
    end
    endtask
endmodule

// ---- testbench/tb_top.sv ----
// testbench for the two-wire register port with a host master model
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk; // 250 MHz system clock
    logic rst_n; // async reset, active low
    logic scl; // bus clock, also the link clock
    logic sdaHostLow; // host pulls data low
    wire sda; // resolved data line with pull-up
    logic sdaOut;
    logic sdaOe;
    logic addrStrap;
    logic undervoltageLockoutOk;
    logic overheatFlag;
    lnbi_pkg::lnbi_chan_flags_s ch1Flags;
    lnbi_pkg::lnbi_chan_flags_s ch2Flags;
    lnbi_pkg::lnbi_chan_ctrl_s [1:0] chanCtrl;
    lnbi_pkg::lnbi_chan_ctrl_s [1:0] expCtrl; // expected control bits
    logic [2:0] expSel; // expected selection
    logic ackA; // address acknowledged
    logic ackD; // data acknowledged
    logic [7:0] rd; // byte read back
    int nFail;
    int numChecks;
    // one write to each writable register kind of both channels
    // spare bits are written as ones in 8'h3f and 8'hfe so that their reading back as zero is seen
    logic [7:0] wrTab [6] = '{8'h3f, 8'h55, 8'h73, 8'hb4, 8'hca, 8'hfe};

    // wired-and of both parties over the pull-up
    assign sda = (sdaHostLow || (sdaOe && !sdaOut)) ? 1'h0 : 1'h1;

    lnbi_i2c_port dut (
        .clk(clk), .rst_n(rst_n), .sclClk(scl), .sclIn(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrap(addrStrap),
        .undervoltageLockoutOk(undervoltageLockoutOk), .overheatFlag(overheatFlag),
        .ch1Flags(ch1Flags), .ch2Flags(ch2Flags), .chanCtrl(chanCtrl)
    );

    lnbi_host_model host (
        .scl(scl), .sdaLow(sdaHostLow), .sda(sda)
    );

    // system clock
    initial
    begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // compare helpers, one per result kind
    task automatic checkBit(input logic got, input logic exp, input string m);
        numChecks++;
        if (got !== exp)
        begin
            nFail++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask
    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input string m);
        numChecks++;
        if (got !== exp)
        begin
            nFail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic checkCtrl();
        numChecks++;
        if (chanCtrl !== expCtrl)
        begin
            nFail++;
            $display("MISMATCH t=%0t controls got %h exp %h", $time, chanCtrl, expCtrl);
        end
    endtask

    // address byte for the strap setting and direction
    function automatic logic [7:0] addr(input logic dir);
        addr = {lnbi_pkg::DEV_ADDR_HI, addrStrap, dir};
    endfunction

    // expected read contents of a selected register
    function automatic logic [7:0] regByte(input logic [2:0] s);
        lnbi_pkg::lnbi_chan_ctrl_s c;
        c = expCtrl[s[2]];
        case (s[1:0])
            lnbi_pkg::KIND_STATUS:
                regByte = s[2] ? {s, 1'h0, ch2Flags} : {s, overheatFlag, ch1Flags};
            lnbi_pkg::KIND_TONE:
                regByte = {s, c.toneContinuousOn, c.extModSelect, c.detectThresholdSel, 2'h0};
            lnbi_pkg::KIND_COMMAND:
                regByte = {s, c.staticLimitSel, c.pinVoltSelectEn, c.limitRangeBit,
                           c.limitHighBit, c.limitLowBit};
            default:
                regByte = {s, c.powerOn, 2'h0, c.highRangeSel, c.lowRangeSel};
        endcase
    endfunction

    // reference update for an accepted data byte
    task automatic modelWrite(input logic [7:0] d);
        lnbi_pkg::lnbi_chan_ctrl_s c;
        c = expCtrl[d[7]];
        expSel = d[7:5];
        case (d[6:5])
            lnbi_pkg::KIND_TONE:
                {c.toneContinuousOn, c.extModSelect, c.detectThresholdSel} = d[4:2];
            lnbi_pkg::KIND_COMMAND:
                {c.staticLimitSel, c.pinVoltSelectEn, c.limitRangeBit, c.limitHighBit,
                 c.limitLowBit} = d[4:0];
            lnbi_pkg::KIND_CONTROL:
                {c.powerOn, c.highRangeSel, c.lowRangeSel} = {d[4], d[1:0]};
            default:
                ; // status byte: flags untouched
        endcase
        expCtrl[d[7]] = c;
    endtask

    // bus frames: start, address, one byte, stop
    task automatic busWrite(input logic [7:0] a, input logic [7:0] d);
        host.startCond();
        host.sendByte(a, ackA);
        host.sendByte(d, ackD);
        host.stopCond();
    endtask
    task automatic busRead(input logic [7:0] a);
        host.startCond();
        host.sendByte(a, ackA);
        host.recvByte(1'h0, rd);
        host.stopCond();
    endtask

    // accepted write, then read back of the selected register
    task automatic writeCheck(input logic [7:0] d);
        busWrite(addr(1'h0), d);
        modelWrite(d);
        checkBit(ackA, 1'h1, "address ack");
        checkBit(ackD, 1'h1, "data ack");
        checkCtrl();
        busRead(addr(lnbi_pkg::DIR_READ));
        checkByte(rd, regByte(expSel), "read back");
    endtask

    // verdict and end of run
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog on a hung bus
    initial
    begin
        #200us;
        nFail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tallyAndFinish();
    end

    // main sequence
    initial
    begin
        rst_n = 1'h0;
        addrStrap = 1'h0;
        undervoltageLockoutOk = 1'h1;
        overheatFlag = 1'h0;
        ch1Flags = 4'h0;
        ch2Flags = 4'h0;
        expCtrl = '0;
        expSel = 3'h0;
        nFail = 0;
        numChecks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk) overheatFlag <= 1'h1;
        ch1Flags <= 4'ha;
        ch2Flags <= 4'h5;
        repeat (8) @(posedge clk);
        #7;
        // reset state and first read of channel one status
        checkCtrl();
        checkBit(sdaOe, 1'h0, "idle release");
        checkBit(sdaOut, 1'h0, "open drain low");
        busRead(addr(lnbi_pkg::DIR_READ));
        checkBit(ackA, 1'h1, "read ack");
        checkByte(rd, regByte(3'h0), "status one");
        $display("test reset done");
        // every writable register of both channels
        foreach (wrTab[i])
            writeCheck(wrTab[i]);
        $display("test register writes done");
        // status writes change only the selection
        writeCheck(8'h1f);
        @(posedge clk) overheatFlag <= 1'h0;
        ch1Flags <= 4'h5;
        ch2Flags <= 4'ha;
        writeCheck(8'h9f);
        writeCheck(8'h1f);
        $display("test status done");
        // foreign addresses are ignored
        busWrite({lnbi_pkg::DEV_ADDR_HI, ~addrStrap, 1'h0}, 8'h60);
        checkBit(ackA, 1'h0, "strap mismatch ack");
        checkBit(ackD, 1'h0, "strap mismatch data");
        busWrite({6'h0c, addrStrap, 1'h0}, 8'h60);
        checkBit(ackA, 1'h0, "pattern mismatch ack");
        checkCtrl();
        @(posedge clk) addrStrap <= 1'h1;
        repeat (8) @(posedge clk);
        writeCheck(8'h60);
        $display("test addressing done");
        // no acknowledge while power is not good
        @(posedge clk) undervoltageLockoutOk <= 1'h0;
        repeat (8) @(posedge clk);
        busWrite(addr(1'h0), 8'h73);
        checkBit(ackA, 1'h0, "lockout ack");
        checkCtrl();
        @(posedge clk) undervoltageLockoutOk <= 1'h1;
        repeat (8) @(posedge clk);
        writeCheck(8'h73);
        $display("test lockout done");
        tallyAndFinish();
    end
endmodule
